// *** include/fb_pkg.sv ***
// shared constants and types for the fieldbus slot and shared-data image
package fb_pkg;
    // ************************************************
    // image geometry
    // ************************************************
    localparam int DIN_WORDS  = 16;
    localparam int DOUT_WORDS = 28;
    localparam int RD_WORDS   = 10;
    localparam logic [4:0] RD_LAST_OFS   = 5'h0a;
    localparam logic [2:0] INT_IN_PER    = 3'h2;
    localparam logic [2:0] INT_OUT_PER   = 3'h2;
    localparam logic [2:0] FLT_IN_PER    = 3'h4;
    localparam logic [2:0] FLT_OUT_PER   = 3'h3;
    localparam logic [4:0] FLT_OUT_OFS   = 5'h01;
    localparam logic [4:0] SD_INT_IO     = 5'h17;
    localparam logic [4:0] SD_FLT_IO     = 5'h1c;
    localparam logic [4:0] SD_INT_IN_B   = 5'h08;
    localparam logic [4:0] SD_FLT_IN_B   = 5'h10;
    localparam logic [4:0] SD_INT_OUT_B  = 5'h08;
    localparam logic [4:0] SD_FLT_OUT_B  = 5'h0d;
    localparam logic [1:0] FLT_STAT_POS  = 2'h3;
    // ************************************************
    // status word bits and shared-data codes
    // ************************************************
    localparam int ST_OK_BIT  = 15;
    localparam int ST_UPD_BIT = 14;
    localparam int ST_INT_BIT = 13;
    localparam int CMD_STR_BIT = 8;
    localparam logic [7:0] CMD_NULL  = 8'h00;
    localparam logic [7:0] CMD_READ  = 8'h01;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [15:0] SDS_NULL  = 16'h0000;
    localparam logic [15:0] SDS_OK    = 16'h0001;
    localparam logic [15:0] SDS_NAME  = 16'h0002;
    localparam logic [15:0] SDS_CMD   = 16'h0003;
    localparam logic [15:0] SDS_PROT  = 16'h0004;
    // ************************************************
    // register map (byte addresses)
    // ************************************************
    localparam logic [8:0] REG_CFG    = 9'h000;
    localparam logic [8:0] REG_SIZE   = 9'h004;
    localparam logic [8:0] REG_CTRL   = 9'h008;
    localparam logic [8:0] REG_SDREQ  = 9'h00c;
    localparam logic [8:0] REG_SDRSP  = 9'h010;
    localparam logic [8:0] REG_SDSTAT = 9'h014;
    localparam logic [1:0] WIN_DIN    = 2'h1;
    localparam logic [1:0] WIN_DOUT   = 2'h2;
    localparam logic [8:0] REG_RD_B   = 9'h100;
    localparam logic [8:0] REG_RD_E   = 9'h128;
    localparam int CTRL_UPD_BIT = 0;
    localparam int CTRL_OK_BIT  = 1;
    localparam int SDREQ_PEND_BIT = 16;

    typedef enum logic [1:0] {FMT_INT = 2'h0, FMT_DIV = 2'h1, FMT_FLT = 2'h2} fmt_t;
    typedef struct packed {
        logic [6:0] node;
        logic       sd_en;
        fmt_t       fmt;
        logic [1:0] slots_m1;
    } cfg_t;
    localparam cfg_t CFG_RST = '{node: 7'h00, sd_en: 1'b0, fmt: FMT_INT, slots_m1: 2'h0};
    typedef struct packed {
        logic [4:0] in_words;
        logic [4:0] out_words;
        logic [4:0] sd_in_base;
        logic [4:0] sd_out_base;
    } layout_t;
    typedef struct packed {
        logic        valid;
        logic        wr;
        logic [6:0]  node;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } link_req_t;
    typedef struct packed {
        logic found;
        logic prot;
        logic is_str;
    } sd_rsp_t;
endpackage

// *** logic/fb_layout.sv ***
// image sizes and shared-data area bases from the configuration
`timescale 1ns/100ps
module fb_layout (
    // configuration
    input  wire fb_pkg::cfg_t    i_cfg,
    // resulting layout
    output fb_pkg::layout_t      o_layout
);
    logic [4:0] n;

    // word counts per slot and format, fixed sizes with shared data
    always_comb begin
        n = 5'(i_cfg.slots_m1) + 5'h01; // five bits so four slots times four words does not wrap
        o_layout = '0;
        if (i_cfg.fmt == fb_pkg::FMT_FLT) begin
            o_layout.in_words    = 5'(n * fb_pkg::FLT_IN_PER);
            o_layout.out_words   = 5'(n * fb_pkg::FLT_OUT_PER) + fb_pkg::FLT_OUT_OFS;
            o_layout.sd_in_base  = fb_pkg::SD_FLT_IN_B;
            o_layout.sd_out_base = fb_pkg::SD_FLT_OUT_B;
        end else begin
            o_layout.in_words    = 5'(n * fb_pkg::INT_IN_PER);
            o_layout.out_words   = 5'(n * fb_pkg::INT_OUT_PER);
            o_layout.sd_in_base  = fb_pkg::SD_INT_IN_B;
            o_layout.sd_out_base = fb_pkg::SD_INT_OUT_B;
        end
        if (i_cfg.sd_en) begin
            o_layout.in_words  = (i_cfg.fmt == fb_pkg::FMT_FLT) ? fb_pkg::SD_FLT_IO : fb_pkg::SD_INT_IO;
            o_layout.out_words = o_layout.in_words;
        end
    end
endmodule

// *** logic/fb_sd_interp.sv ***
// shared-data command interpreter: change detection, status and read validity
`timescale 1ns/100ps
module fb_sd_interp (
    // clock and reset
    input  wire logic            i_clk,
    input  wire logic            i_rst,
    // command from the output image
    input  wire logic            i_en,
    input  wire logic [15:0]     i_cmd,
    // lookup answer from software
    input  wire logic            i_rsp_valid,
    input  wire fb_pkg::sd_rsp_t i_rsp,
    // results
    output logic [15:0]          o_status,
    output logic [15:0]          o_cmd,
    output logic                 o_pending,
    output logic                 o_rd_valid
);
    typedef enum logic {SD_IDLE, SD_WAIT} sd_state_t;
    typedef struct packed {
        sd_state_t   state;
        logic [15:0] prev;
        logic [15:0] cmd;
        logic [15:0] status;
        logic        rdv;
    } sd_st_t;
    sd_st_t s_reg;
    sd_st_t s_next;
    logic   is_wr;

    // act only on a changed command word; answer once per change
    always_comb begin
        s_next = s_reg;
        is_wr  = (s_reg.cmd[7:0] == fb_pkg::CMD_WRITE);
        if (!i_en) begin
            s_next = '0;
        end else if (i_cmd != s_reg.prev) begin
            s_next.prev  = i_cmd;
            s_next.cmd   = i_cmd;
            s_next.state = SD_IDLE;
            if (i_cmd[7:0] == fb_pkg::CMD_NULL) begin
                s_next.status = fb_pkg::SDS_NULL;
            end else if (i_cmd[7:0] == fb_pkg::CMD_READ || i_cmd[7:0] == fb_pkg::CMD_WRITE) begin
                s_next.state  = SD_WAIT;
                s_next.status = fb_pkg::SDS_NULL;
            end else begin
                s_next.status = fb_pkg::SDS_CMD;
            end
        end else begin
            case (s_reg.state)
                SD_WAIT: begin
                    if (i_rsp_valid) begin
                        s_next.state = SD_IDLE;
                        s_next.rdv   = 1'b0;
                        if (!i_rsp.found) begin
                            s_next.status = fb_pkg::SDS_NAME;
                        end else if (is_wr && i_rsp.prot) begin
                            s_next.status = fb_pkg::SDS_PROT;
                        end else if (is_wr && (s_reg.cmd[fb_pkg::CMD_STR_BIT] != i_rsp.is_str)) begin
                            s_next.status = fb_pkg::SDS_CMD;
                        end else begin
                            s_next.status = fb_pkg::SDS_OK;
                            s_next.rdv    = ~is_wr;
                        end
                    end
                end
                default: s_next.state = SD_IDLE;
            endcase
        end
    end

    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_status   = s_reg.status;
    assign o_cmd      = s_reg.cmd;
    assign o_pending  = (s_reg.state == SD_WAIT);
    assign o_rd_valid = s_reg.rdv;
endmodule

// *** logic/fb_slot_image.sv ***
// cyclic slot image with shared-data channel, fieldbus link and register slave
// Function
// - integer slot gives weight word, status word
// - one to four slots, same format
// - slot data integer, division or float
// - word counts from slots, format, shared data
// - master reads inputs, writes outputs each cycle
// - every slot owns its own image words
// - shared data appended only when enabled
// - value length at most ten words
// - read field present only after read
// - refuse string/float type mismatched writes
// - status word codes zero to four
// - shared input: status then read field
// - status shows ok, update, integrity bits
// - answer only at configured node address
// - execute only on changed command word
// - integer/division slot two words each way
// - float slot four in, three out words
`timescale 1ns/100ps
module fb_slot_image (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    // avalon-mm register slave
    input  wire logic [8:0]        i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic [31:0]            o_avs_readdata,
    output logic                   o_avs_waitrequest,
    // fieldbus controller link
    input  wire fb_pkg::link_req_t i_link,
    output logic [15:0]            o_link_rdata,
    output logic                   o_link_ack,
    // image sizes and shared-data state
    output logic [4:0]             o_in_words,
    output logic [4:0]             o_out_words,
    output logic                   o_sd_pending
);
    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        fb_pkg::cfg_t                           cfg;
        fb_pkg::layout_t                        lay;
        logic                                   upd;
        logic                                   ok;
        logic                                   integ;
        logic [fb_pkg::DIN_WORDS-1:0][15:0]     din;
        logic [fb_pkg::DOUT_WORDS-1:0][15:0]    dout;
        logic [fb_pkg::RD_WORDS-1:0][15:0]      rdf;
        logic                                   wreq;
        logic [31:0]                            rdata;
        logic                                   lack;
        logic [15:0]                            lrdata;
    } st_t;
    st_t             st_reg;
    st_t             st_next;
    fb_pkg::layout_t lay_comb;
    logic [15:0]     sd_status;
    logic [15:0]     sd_cmd;
    logic            sd_pend;
    logic            sd_rdv;
    logic            rsp_valid;
    logic [15:0]     sd_cmd_word;
    logic [31:0]     rmux;
    logic [4:0]      oidx;

    // ************************************************
    // helpers
    // ************************************************
    // input image word as the master sees it
    function automatic logic [15:0] link_word(input st_t s, input logic [15:0] stat_w,
                                              input logic rd_ok, input logic [4:0] idx);
        logic [4:0]  off;
        logic [15:0] w;
        logic        is_stat;
        off     = 5'(idx - s.lay.sd_in_base);
        w       = 16'h0000;
        is_stat = (s.cfg.fmt == fb_pkg::FMT_FLT) ? (idx[1:0] == fb_pkg::FLT_STAT_POS)
                                                 : idx[0];
        if (s.cfg.sd_en && idx >= s.lay.sd_in_base) begin
            if (off == 5'h00) begin
                w = stat_w;
            end else if (rd_ok && off <= fb_pkg::RD_LAST_OFS) begin
                w = s.rdf[4'(off - 5'h01)];
            end
        end else if (idx < s.lay.in_words && !idx[4]) begin
            w = s.din[idx[3:0]];
            if (is_stat) begin
                w[fb_pkg::ST_OK_BIT]  = s.ok & ~s.upd;
                w[fb_pkg::ST_UPD_BIT] = s.upd;
                w[fb_pkg::ST_INT_BIT] = s.integ;
            end
        end
        return w;
    endfunction

    // byte-lane merge for the low half of a register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // ************************************************
    // submodules
    // ************************************************
    // sizes follow slots, format and shared-data enable
    fb_layout u_layout (
        .i_cfg    (st_reg.cfg),
        .o_layout (lay_comb)
    );

    // shared-data command word sits at the head of the output shared area
    assign sd_cmd_word = st_reg.dout[st_reg.lay.sd_out_base];

    fb_sd_interp u_sd (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_en        (st_reg.cfg.sd_en),
        .i_cmd       (sd_cmd_word),
        .i_rsp_valid (rsp_valid),
        .i_rsp       (fb_pkg::sd_rsp_t'(i_avs_writedata[2:0])),
        .o_status    (sd_status),
        .o_cmd       (sd_cmd),
        .o_pending   (sd_pend),
        .o_rd_valid  (sd_rdv)
    );

    // ************************************************
    // register read mux
    // ************************************************
    // unmapped addresses read zero and still complete
    always_comb begin
        rmux = 32'h0000_0000;
        oidx = i_avs_address[6:2];
        if (i_avs_address == fb_pkg::REG_CFG) begin
            rmux[15:0] = 16'(st_reg.cfg);
        end else if (i_avs_address == fb_pkg::REG_SIZE) begin
            rmux[15:0] = {3'h0, st_reg.lay.out_words, 3'h0, st_reg.lay.in_words};
        end else if (i_avs_address == fb_pkg::REG_CTRL) begin
            rmux[fb_pkg::CTRL_UPD_BIT] = st_reg.upd;
            rmux[fb_pkg::CTRL_OK_BIT]  = st_reg.ok;
        end else if (i_avs_address == fb_pkg::REG_SDREQ) begin
            rmux[15:0] = sd_cmd;
            rmux[fb_pkg::SDREQ_PEND_BIT] = sd_pend;
        end else if (i_avs_address == fb_pkg::REG_SDSTAT) begin
            rmux[15:0] = sd_status;
        end else if (!i_avs_address[8] && i_avs_address[7:6] == fb_pkg::WIN_DIN) begin
            rmux[15:0] = st_reg.din[i_avs_address[5:2]];
        end else if (!i_avs_address[8] && i_avs_address[7] && oidx < 5'(fb_pkg::DOUT_WORDS)) begin
            rmux[15:0] = st_reg.dout[oidx];
        end else if (i_avs_address >= fb_pkg::REG_RD_B && i_avs_address < fb_pkg::REG_RD_E) begin
            rmux[15:0] = st_reg.rdf[4'(i_avs_address[5:2])];
        end
    end

    // lookup answer is taken at the completion edge of its write
    assign rsp_valid = !st_reg.wreq && i_avs_write && i_avs_address == fb_pkg::REG_SDRSP;

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        st_next      = st_reg;
        st_next.lay  = lay_comb;
        st_next.lack = 1'b0;

        // avalon: wait one cycle, then complete with waitrequest low
        if (!st_reg.wreq) begin
            st_next.wreq = 1'b1;
            if (i_avs_write) begin
                if (i_avs_address == fb_pkg::REG_CFG) begin
                    st_next.cfg = fb_pkg::cfg_t'(12'(merge16(16'(st_reg.cfg), i_avs_writedata,
                                                             i_avs_byteenable)));
                end else if (i_avs_address == fb_pkg::REG_CTRL && i_avs_byteenable[0]) begin
                    st_next.upd = i_avs_writedata[fb_pkg::CTRL_UPD_BIT];
                    st_next.ok  = i_avs_writedata[fb_pkg::CTRL_OK_BIT];
                    if (st_reg.upd && !i_avs_writedata[fb_pkg::CTRL_UPD_BIT]) begin
                        st_next.integ = ~st_reg.integ;
                    end
                end else if (!i_avs_address[8] && i_avs_address[7:6] == fb_pkg::WIN_DIN) begin
                    st_next.din[i_avs_address[5:2]] = merge16(st_reg.din[i_avs_address[5:2]],
                                                              i_avs_writedata, i_avs_byteenable);
                end else if (i_avs_address >= fb_pkg::REG_RD_B && i_avs_address < fb_pkg::REG_RD_E) begin
                    st_next.rdf[4'(i_avs_address[5:2])] = merge16(st_reg.rdf[4'(i_avs_address[5:2])],
                                                                  i_avs_writedata,
                                                                  i_avs_byteenable);
                end
            end
        end else if (i_avs_read || i_avs_write) begin
            st_next.wreq  = 1'b0;
            st_next.rdata = i_avs_read ? rmux : 32'h0000_0000;
        end

        // fieldbus link: serve only our own node address
        if (i_link.valid && i_link.node == st_reg.cfg.node) begin
            st_next.lack = 1'b1;
            if (i_link.wr) begin
                st_next.lrdata = 16'h0000;
                if (i_link.addr < st_reg.lay.out_words) begin
                    st_next.dout[i_link.addr] = i_link.wdata;
                end
            end else begin
                st_next.lrdata = link_word(st_reg, sd_status, sd_rdv, i_link.addr);
            end
        end
    end

    // ************************************************
    // registers
    // ************************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg      <= '0;
            st_reg.cfg  <= fb_pkg::CFG_RST;
            st_reg.wreq <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register, pending from the interpreter's
    assign o_avs_readdata    = st_reg.rdata;
    assign o_avs_waitrequest = st_reg.wreq;
    assign o_link_rdata      = st_reg.lrdata;
    assign o_link_ack        = st_reg.lack;
    assign o_in_words        = st_reg.lay.in_words;
    assign o_out_words       = st_reg.lay.out_words;
    assign o_sd_pending      = sd_pend;
endmodule

// *** test/fb_slot_image_monitor.sv ***
// port checks for the slot image
`timescale 1ns/100ps
module fb_slot_image_monitor (
    // clock and reset
    input wire logic              i_clk,
    input wire logic              i_rst,
    // register bus
    input wire logic              i_avs_read,
    input wire logic              i_avs_write,
    input wire logic              o_avs_waitrequest,
    // link and image state
    input wire fb_pkg::link_req_t i_link,
    input wire logic [15:0]       o_link_rdata,
    input wire logic              o_link_ack,
    input wire logic [4:0]        o_in_words,
    input wire logic [4:0]        o_out_words,
    input wire logic              o_sd_pending
);
    // ********************
    // checks, quiet in reset
    // ********************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // request taken, then one cycle of answer
    sequence s_taken;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_answer;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence
    a_bus_one_wait: assert property (s_taken |=> s_answer)
        else $error("bus answer not one cycle");
    a_ack_cause: assert property (o_link_ack |-> $past(i_link.valid))
        else $error("ack without request");
    a_read_beyond: assert property (o_link_ack && $past(!i_link.wr && i_link.addr >= o_in_words)
        |-> o_link_rdata == 16'h0000) else $error("read beyond image not zero");
    a_size_legal: assert property (o_in_words != 5'h00
        |-> o_in_words inside {5'h02, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h17, 5'h1c}) else $error("bad size");
    a_shared_pair: assert property (o_in_words inside {5'h17, 5'h1c} |-> o_out_words == o_in_words)
        else $error("shared sizes differ");
    a_int_pair: assert property (o_in_words inside {5'h02, 5'h06} |-> o_out_words == o_in_words)
        else $error("integer sizes differ");
    a_float_out: assert property (o_in_words inside {5'h0c, 5'h10}
        |-> o_out_words == o_in_words - (o_in_words >> 2) + 5'h01) else $error("float output size");
    a_status_flags: assert property (o_link_ack && o_in_words == 5'h02
        && $past(!i_link.wr && i_link.addr == 5'h01) |-> !(o_link_rdata[15] && o_link_rdata[14]))
        else $error("ok and update both set");
    a_pend_cause: assert property ($rose(o_sd_pending)
        |-> $past(o_link_ack) || $past(o_link_ack, 2) || $past(o_link_ack, 3)) else $error("pending uncaused");
endmodule

// *** test/fb_plc_master.sv ***
// fieldbus master model: one request at a time on the link
`timescale 1ns/100ps
module fb_plc_master (
    // clock
    input  wire logic         i_clk,
    // answer from the slot image
    input  wire logic         i_ack,
    input  wire logic [15:0]  i_rdata,
    // request towards the slot image
    output fb_pkg::link_req_t o_link
);
    logic        last_ack = 1'b0;
    logic [15:0] last_rdata = 16'h0000;
    // quiet link at start
    initial o_link = '0;
    // one request, idle fields inverted, gap sets the pace
    task automatic xfer(input logic wr, input logic [6:0] nd, input logic [4:0] a,
                        input logic [15:0] d, input int gap);
        @(posedge i_clk);
        o_link <= '{1'b1, wr, nd, a, d};
        @(posedge i_clk);
        o_link <= '{1'b0, ~wr, ~nd, ~a, ~d};
        @(negedge i_clk);
        last_ack = i_ack;
        last_rdata = i_rdata;
        repeat (gap) @(posedge i_clk);
    endtask
endmodule

// *** test/fb_slot_image_tb.sv ***
// self-checking bench for the slot image
`timescale 1ns/100ps
module fb_slot_image_tb;
    // ********************
    // signals and state
    // ********************
    logic              i_clk = 1'b0;
    logic              i_rst = 1'b1;
    logic [8:0]        i_avs_address = 9'h000;
    logic              i_avs_read = 1'b0;
    logic              i_avs_write = 1'b0;
    logic [31:0]       i_avs_writedata = 32'h0;
    logic [31:0]       o_avs_readdata;
    logic              o_avs_waitrequest;
    fb_pkg::link_req_t i_link;
    logic [15:0]       o_link_rdata;
    logic              o_link_ack;
    logic [4:0]        o_in_words;
    logic [4:0]        o_out_words;
    logic              o_sd_pending;
    logic [31:0]       seed = 32'h0000c6da;
    logic [31:0]       rd;
    logic [15:0]       w;
    logic [15:0]       rf [10];
    logic [6:0]        node = 7'h00;
    logic [15:0]       cmds [6] = '{16'h0001, 16'h0001, 16'h0002, 16'h0102, 16'h0002, 16'h0005};
    logic [2:0]        rsps [6] = '{3'h4, 3'h0, 3'h6, 3'h4, 3'h4, 3'h4}; // found bit 2, protected 1, string 0
    logic [15:0]       stats [6] = '{fb_pkg::SDS_OK, fb_pkg::SDS_NAME, fb_pkg::SDS_PROT,
                                     fb_pkg::SDS_CMD, fb_pkg::SDS_OK, fb_pkg::SDS_CMD};
    int                fails = 0;
    int                checked = 0;
    // clock of 100 ns
    always #50 i_clk = ~i_clk;
    fb_slot_image dut (.i_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
        .i_avs_byteenable(4'h3), .o_avs_readdata, .o_avs_waitrequest, .i_link, .o_link_rdata,
        .o_link_ack, .o_in_words, .o_out_words, .o_sd_pending);
    fb_plc_master plc (.i_clk, .i_ack(o_link_ack), .i_rdata(o_link_rdata), .o_link(i_link));
    // xorshift source
    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    // expected size register: in words low, out words at bit 8
    function automatic logic [31:0] exp_size(input int n, input int f, input int s);
        logic [4:0] iw;
        logic [4:0] ow;
        iw = 5'((f == 2) ? 4 * n : 2 * n);
        ow = 5'((f == 2) ? 3 * n + 1 : 2 * n);
        if (s == 1) begin
            iw = (f == 2) ? 5'h1c : 5'h17;
            ow = iw;
        end
        return {19'h0, ow, 3'h0, iw};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // one bus transfer, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [8:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        for (n = 0; n < 20; n++) begin
            @(posedge i_clk);
            if (o_avs_waitrequest === 1'b0) break;
        end
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        if (n == 20) begin
            fails++;
            report_and_stop();
        end
    endtask
    task automatic avc(input logic [8:0] a, input logic [31:0] e);
        av(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    task automatic lk(input logic wr, input logic [4:0] a, input logic [15:0] d);
        plc.xfer(wr, node, a, d, int'(xs() % 16'h0003));
    endtask
    task automatic lkc(input logic [4:0] a, input logic [15:0] e);
        lk(1'b0, a, 16'h0000);
        check({16'h0, plc.last_rdata}, {16'h0, e});
    endtask
    // shared command, software lookup answer if one is asked for
    task automatic sd_run(input logic [15:0] c, input logic [2:0] rsp);
        int n;
        lk(1'b1, 5'h08, c);
        for (n = 0; n < 10; n++) begin
            @(negedge i_clk);
            if (o_sd_pending === 1'b1) break;
        end
        if (n < 10) begin
            avc(fb_pkg::REG_SDREQ, {15'h0, 1'b1, c});
            av(1'b1, fb_pkg::REG_SDRSP, {29'h0, rsp});
        end
        repeat (3) @(posedge i_clk);
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        lk(1'b0, 5'h01, 16'h0000);
        avc(9'h030, 32'h0);
        for (int f = 0; f < 3; f++) begin
            for (int n = 1; n < 5; n++) begin
                for (int s = 0; s < 2; s++) begin
                    av(1'b1, fb_pkg::REG_CFG, 32'(n - 1 + 4 * f + 16 * s));
                    avc(fb_pkg::REG_SIZE, exp_size(n, f, s));
                end
            end
        end
        node = 7'(xs() % 16'd125) + 7'h01;
        av(1'b1, fb_pkg::REG_CFG, {20'h0, node, 5'h01});
        av(1'b1, fb_pkg::REG_CTRL, 32'h2);
        for (int i = 0; i < 4; i++) begin
            w = xs();
            av(1'b1, 9'(9'h040 + 4 * i), {16'h0, w});
            lk(1'b0, 5'(i), 16'h0000);
            check({16'h0, plc.last_rdata & (i[0] ? 16'hdfff : 16'hffff)},
                  {16'h0, i[0] ? {2'b10, 1'b0, w[12:0]} : w});
            lk(1'b1, 5'(i), w);
            avc(9'(9'h080 + 4 * i), {16'h0, w});
        end
        lkc(5'h05, 16'h0000);
        lk(1'b1, 5'h04, 16'h5a5a);
        avc(9'h090, 32'h0);
        av(1'b1, fb_pkg::REG_CTRL, 32'h3);
        lk(1'b0, 5'h01, 16'h0000);
        check({30'h0, plc.last_rdata[15:14]}, 32'h1);
        av(1'b1, fb_pkg::REG_CTRL, 32'h2);
        lk(1'b0, 5'h01, 16'h0000);
        check({29'h0, plc.last_rdata[15:13]}, 32'h5);
        plc.xfer(1'b0, node + 7'h01, 5'h00, 16'h0000, 0);
        check({31'h0, plc.last_ack}, 32'h0);
        av(1'b1, fb_pkg::REG_CFG, {20'h0, node, 5'h10});
        for (int j = 0; j < 10; j++) begin
            rf[j] = xs();
            av(1'b1, 9'(9'h100 + 4 * j), {16'h0, rf[j]});
        end
        for (int k = 0; k < 6; k++) begin
            lk(1'b1, 5'h08, 16'h0000);
            for (int j = 9; j < 14; j++) lk(1'b1, 5'(j), xs());
            repeat (3) @(posedge i_clk);
            lkc(5'h08, fb_pkg::SDS_NULL);
            lkc(5'h09, (k == 1) ? rf[0] : 16'h0000);
            sd_run(cmds[k], rsps[k]);
            lkc(5'h08, stats[k]);
            lkc(5'h09, (k == 0) ? rf[0] : 16'h0000);
            if (k == 0) begin
                for (int j = 1; j < 10; j++) lkc(5'(9 + j), rf[j]);
                lk(1'b1, 5'h08, 16'h0001);
                repeat (4) @(negedge i_clk);
                check({31'h0, o_sd_pending}, 32'h0);
            end
        end
        report_and_stop();
    end
endmodule
bind fb_slot_image fb_slot_image_monitor mon (.i_clk, .i_rst, .i_avs_read, .i_avs_write,
    .o_avs_waitrequest, .i_link, .o_link_rdata, .o_link_ack, .o_in_words, .o_out_words, .o_sd_pending);
